// ===== rcc_pkg.sv
/*
 Package for the remote contact control and status block: timing,
 APB register map, field positions, input indices and the state record.
 Assumes a 40 MHz controller clock.
*/
package rcc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ         = 40_000_000;
	localparam int unsigned DEBOUNCE_MS    = 10;
	localparam int unsigned DEBOUNCE_CYC   = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int unsigned RESET_HOLD_S   = 3;
	localparam int unsigned RESET_HOLD_CYC = CLK_HZ * RESET_HOLD_S;
	localparam int unsigned INIT_MS        = 50;
	localparam int unsigned INIT_CYC       = CLK_HZ / 1000 * INIT_MS;
	localparam int unsigned SECOND_CYC     = CLK_HZ;

	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_STATUS  = 8'h04;
	localparam logic [7:0] A_DISP    = 8'h08;
	localparam logic [7:0] A_RUNTIME = 8'h0c;
	localparam logic [7:0] A_CMD     = 8'h10;
	localparam int CTRL_LEGACY = 0;
	localparam int CMD_COMP    = 0;
	localparam int CMD_COLD    = 1;
	localparam int CMD_ON      = 2;

	// ----------------------------------------------------------------
	// Debounced inputs and sensors
	// ----------------------------------------------------------------
	localparam int NIN        = 7;
	localparam int IN_RST     = 0;
	localparam int IN_COLD    = 1;
	localparam int IN_COMP    = 2;
	localparam int BT_OFF     = 3;
	localparam int BT_ON      = 4;
	localparam int BT_MENU    = 5;
	localparam int BT_HIST    = 6;
	localparam int NSEN       = 3;
	localparam int SN_PRESS   = 0;
	localparam int SN_TEMP    = 1;
	localparam int SN_PHASE   = 2;
	localparam int HIST_DEPTH = 8;

	typedef enum logic [2:0] {
		SCR_INIT   = 3'b000,
		SCR_STATUS = 3'b001,
		SCR_FAULT  = 3'b010,
		SCR_HIST   = 3'b011,
		SCR_HOURS  = 3'b100,
		SCR_CHECKS = 3'b101
	} screen_t;

	typedef struct packed {
		logic [NIN-1:0]             in_s1;
		logic [NIN-1:0]             in_s2;
		logic [NIN-1:0]             db;
		logic [NIN-1:0][31:0]       dbc;
		logic [NSEN-1:0]            sen_s1;
		logic [NSEN-1:0]            sen_s2;
		logic [NSEN-1:0]            sen_prev;
		logic [3:0]                 pin_s1;
		logic [3:0]                 pin_s2;
		logic                       legacy;
		logic                       comp_on;
		logic                       cold_on;
		logic                       valve_on;
		logic                       phase_lock;
		logic                       proc_rst;
		logic [31:0]                rst_cnt;
		logic [31:0]                init_cnt;
		logic [31:0]                sec_cnt;
		logic [31:0]                run_sec;
		screen_t                    scr;
		logic [1:0]                 fidx;
		logic [2:0]                 hidx;
		logic [3:0]                 hcnt;
		logic [2:0]                 hwr;
		logic [HIST_DEPTH-1:0][1:0] hlog;
		logic [3:0]                 oe;
		logic                       latched;
		logic                       slverr;
		logic [31:0]                prdata;
	} state_t;

	localparam state_t ST_RST = '0;

endpackage

// ===== remote_contact_control_status.sv
/*
 Remote contact control and status with front-panel button handling.
 Assumes contact, button and sensor inputs arrive asynchronously and
 that the open-drain status wires are resolved outside from o_stat_oe.
*/
// Notes on behaviour
// (RULE1) Newer mode: enable contact closing turns its subsystem on.
// (RULE2) Newer mode: enable contact opening turns its subsystem off.
// (RULE3) Panel, software and contact commands act on latest event.
// (RULE4) Far end reopens a closed enable 100 ms to repeat on.
// (RULE5) Far end closes an open enable 100 ms to repeat off.
// (RULE6) Reset contact held 3 s resets processor; shorter does nothing.
// (RULE7) Status pins pull to ground when asserted, float otherwise.
// (RULE8) Pressure alarm while pressure low and system running.
// (RULE9) Phase error pin follows the phase fault.
// (RULE10) Temperature alarm follows over-temperature.
// (RULE11) Run pin while compressor or coldhead runs.
// (RULE12) Off button stops everything, overriding remote contacts.
// (RULE13) On button starts everything unless an interlock is active.
// (RULE14) Phase fault latches and blocks starts until power cycle.
// (RULE15) Menu walks status and active faults; history goes to status.
// (RULE16) History opens newest entry, steps older, wraps to newest.
// (RULE17) Legacy mode: Off always stops; On ignored on failed check.
// (RULE18) Legacy mode: Menu shows checks on error, else hours.
// (RULE19) Legacy mode: closed enable restarts system after power-up.
// (RULE20) After initialisation the status screen is shown.
// (RULE21) Every contact is synchronised and debounced before use.
`timescale 1ns/1ps
module remote_contact_control_status #(
	parameter int unsigned DEBOUNCE_CYCLES   = rcc_pkg::DEBOUNCE_CYC,
	parameter int unsigned RESET_HOLD_CYCLES = rcc_pkg::RESET_HOLD_CYC,
	parameter int unsigned INIT_CYCLES       = rcc_pkg::INIT_CYC,
	parameter int unsigned SECOND_CYCLES     = rcc_pkg::SECOND_CYC
) (
	// Clock, reset, enable
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Contacts, low when shorted: 0 reset, 1 coldhead, 2 compressor
	input  wire logic [2:0]  i_contact_n,
	// Front-panel buttons
	input  wire logic        i_btn_off,
	input  wire logic        i_btn_on,
	input  wire logic        i_btn_menu,
	input  wire logic        i_btn_hist,
	// Fault sensing
	input  wire logic        i_low_press,
	input  wire logic        i_over_temp,
	input  wire logic        i_phase_fault,
	// Open-drain status pins: 0 press, 1 phase, 2 temp, 3 run
	input  wire logic [3:0]  i_stat_pin,
	output logic      [3:0]  o_stat_o,
	output logic      [3:0]  o_stat_oe,
	// Subsystem drives
	output logic             o_comp_on,
	output logic             o_cold_on,
	output logic             o_valve_on,
	output logic             o_proc_rst
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [2:0] next_active(
		input logic [rcc_pkg::NSEN-1:0] mask,
		input logic [1:0]               cur,
		input logic                     from_start
	);
		logic [2:0] r;
		r = 3'h0;
		for (int k = rcc_pkg::NSEN - 1; k >= 0; k--) begin
			if (mask[k] && (from_start || k > int'(cur))) begin
				r = {1'b1, 2'(k)};
			end
		end
		return r;
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		return a == rcc_pkg::A_CTRL || a == rcc_pkg::A_STATUS ||
			a == rcc_pkg::A_DISP || a == rcc_pkg::A_RUNTIME ||
			a == rcc_pkg::A_CMD;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	rcc_pkg::state_t              st;
	rcc_pkg::state_t              nxt;
	logic [rcc_pkg::NIN-1:0]      raw;
	logic [rcc_pkg::NIN-1:0]      rise;
	logic [rcc_pkg::NIN-1:0]      fall;
	logic [rcc_pkg::NSEN-1:0]     sen;
	logic [rcc_pkg::NSEN-1:0]     new_fault;
	logic [2:0]                   pick;
	logic                         acc;
	logic                         sw_cmd;
	logic                         take_remote;
	logic                         init_done;
	logic                         block_start;
	logic                         shutdown;
	logic                         c_on;
	logic                         h_on;
	logic                         c_up;
	logic                         c_dn;
	logic                         h_up;
	logic                         h_dn;
	logic [1:0]                   hcode;
	logic [31:0]                  rd_mux;

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign acc      = i_psel & i_penable;
	assign o_pready = acc & st.latched & i_ce;
	assign o_prdata = st.prdata;
	assign o_pslverr = st.slverr;
	assign o_stat_o  = 4'h0;
	assign o_stat_oe = st.oe;
	assign o_comp_on  = st.comp_on;
	assign o_cold_on  = st.cold_on;
	assign o_valve_on = st.valve_on;
	assign o_proc_rst = st.proc_rst;

	always_comb begin
		nxt = st;

		// ------------------------------------------------------------
		// Synchronise and debounce
		// ------------------------------------------------------------
		raw = {i_btn_hist, i_btn_menu, i_btn_on, i_btn_off, ~i_contact_n};
		nxt.in_s1  = raw;
		nxt.in_s2  = st.in_s1; // RULE21
		nxt.sen_s1 = {i_phase_fault, i_over_temp, i_low_press};
		nxt.sen_s2 = st.sen_s1;
		nxt.pin_s1 = i_stat_pin;
		nxt.pin_s2 = st.pin_s1;
		rise = '0;
		fall = '0;
		for (int i = 0; i < rcc_pkg::NIN; i++) begin
			if (st.in_s2[i] == st.db[i]) begin
				nxt.dbc[i] = 32'h0;
			end else if (st.dbc[i] >= DEBOUNCE_CYCLES - 1) begin
				nxt.db[i]  = st.in_s2[i]; // RULE21
				nxt.dbc[i] = 32'h0;
				rise[i]    = st.in_s2[i];
				fall[i]    = ~st.in_s2[i];
			end else begin
				nxt.dbc[i] = st.dbc[i] + 32'h1;
			end
		end
		sen = st.sen_s2;

		// ------------------------------------------------------------
		// Processor reset hold
		// ------------------------------------------------------------
		if (!st.db[rcc_pkg::IN_RST]) begin
			nxt.rst_cnt  = 32'h0;
			nxt.proc_rst = 1'b0;
		end else if (st.rst_cnt < RESET_HOLD_CYCLES - 1) begin
			nxt.rst_cnt = st.rst_cnt + 32'h1;
		end else begin
			nxt.proc_rst = 1'b1; // RULE6
		end

		// ------------------------------------------------------------
		// Interlocks
		// ------------------------------------------------------------
		if (sen[rcc_pkg::SN_PHASE]) begin
			nxt.phase_lock = 1'b1; // RULE14
		end
		block_start = (|sen) | st.phase_lock; // RULE13 RULE14 RULE17
		shutdown    = sen[rcc_pkg::SN_TEMP] | st.phase_lock;

		// ------------------------------------------------------------
		// Legacy power-up restart
		// ------------------------------------------------------------
		init_done = (st.scr == rcc_pkg::SCR_INIT)
			& (st.init_cnt >= INIT_CYCLES - 1);

		// ------------------------------------------------------------
		// Command arbitration
		// ------------------------------------------------------------
		sw_cmd = acc & st.latched & i_pwrite & (i_paddr == rcc_pkg::A_CMD);
		take_remote = st.legacy | (st.scr != rcc_pkg::SCR_INIT);
		c_up = (take_remote & rise[rcc_pkg::IN_COMP]) // RULE1 RULE19
			| (st.legacy & init_done & st.db[rcc_pkg::IN_COMP]) // RULE19
			| rise[rcc_pkg::BT_ON]
			| (sw_cmd & i_pwdata[rcc_pkg::CMD_COMP]
				& i_pwdata[rcc_pkg::CMD_ON]);
		c_dn = (take_remote & fall[rcc_pkg::IN_COMP]) // RULE2
			| (sw_cmd & i_pwdata[rcc_pkg::CMD_COMP]
				& ~i_pwdata[rcc_pkg::CMD_ON]);
		h_up = (take_remote & rise[rcc_pkg::IN_COLD]) // RULE1
			| rise[rcc_pkg::BT_ON]
			| (sw_cmd & i_pwdata[rcc_pkg::CMD_COLD]
				& i_pwdata[rcc_pkg::CMD_ON]);
		h_dn = (take_remote & fall[rcc_pkg::IN_COLD]) // RULE2
			| (sw_cmd & i_pwdata[rcc_pkg::CMD_COLD]
				& ~i_pwdata[rcc_pkg::CMD_ON]);
		c_on = st.comp_on;
		h_on = st.cold_on;
		if (rise[rcc_pkg::BT_OFF]) begin
			c_on = 1'b0; // RULE12 RULE17
			h_on = 1'b0; // RULE12
		end else begin
			if (c_dn) begin
				c_on = 1'b0; // RULE3
			end else if (c_up && !block_start) begin
				c_on = 1'b1; // RULE3
			end
			if (h_dn) begin
				h_on = 1'b0; // RULE3
			end else if (h_up && !block_start) begin
				h_on = 1'b1; // RULE3
			end
		end
		if (shutdown) begin
			c_on = 1'b0;
			h_on = 1'b0;
		end
		if (st.legacy) begin
			h_on = c_on;
		end
		nxt.comp_on  = c_on;
		nxt.cold_on  = h_on;
		nxt.valve_on = c_on; // RULE12 RULE13

		// ------------------------------------------------------------
		// Status pins
		// ------------------------------------------------------------
		nxt.oe[0] = sen[rcc_pkg::SN_PRESS] & (c_on | h_on); // RULE7 RULE8
		nxt.oe[1] = sen[rcc_pkg::SN_PHASE]; // RULE7 RULE9
		nxt.oe[2] = sen[rcc_pkg::SN_TEMP]; // RULE7 RULE10
		nxt.oe[3] = c_on | h_on; // RULE7 RULE11

		// ------------------------------------------------------------
		// Run time
		// ------------------------------------------------------------
		if (st.comp_on) begin
			if (st.sec_cnt >= SECOND_CYCLES - 1) begin
				nxt.sec_cnt = 32'h0;
				nxt.run_sec = st.run_sec + 32'h1;
			end else begin
				nxt.sec_cnt = st.sec_cnt + 32'h1;
			end
		end

		// ------------------------------------------------------------
		// Fault history
		// ------------------------------------------------------------
		new_fault    = sen & ~st.sen_prev;
		nxt.sen_prev = sen;
		pick = next_active(new_fault, 2'h0, 1'b1);
		if (pick[2]) begin
			nxt.hlog[st.hwr] = pick[1:0] + 2'h1;
			nxt.hwr = st.hwr + 3'h1;
			if (st.hcnt < 4'(rcc_pkg::HIST_DEPTH)) begin
				nxt.hcnt = st.hcnt + 4'h1;
			end
		end
		hcode = st.hlog[3'(st.hwr - 3'h1 - st.hidx)];

		// ------------------------------------------------------------
		// Screens
		// ------------------------------------------------------------
		case (st.scr)
			rcc_pkg::SCR_INIT: begin
				if (st.init_cnt >= INIT_CYCLES - 1) begin
					nxt.scr = rcc_pkg::SCR_STATUS; // RULE20
				end else begin
					nxt.init_cnt = st.init_cnt + 32'h1;
				end
			end
			rcc_pkg::SCR_STATUS, rcc_pkg::SCR_FAULT: begin
				if (rise[rcc_pkg::BT_HIST] && !st.legacy) begin
					nxt.scr  = rcc_pkg::SCR_HIST; // RULE16
					nxt.hidx = 3'h0;
				end else if (rise[rcc_pkg::BT_MENU] && st.legacy) begin
					nxt.scr = block_start ? rcc_pkg::SCR_CHECKS
						: rcc_pkg::SCR_HOURS; // RULE18
				end else if (rise[rcc_pkg::BT_MENU]) begin
					pick = next_active(sen, st.fidx,
						st.scr == rcc_pkg::SCR_STATUS);
					if (st.scr == rcc_pkg::SCR_STATUS) begin
						nxt.scr  = rcc_pkg::SCR_FAULT; // RULE15
						nxt.fidx = pick[1:0];
					end else if (pick[2]) begin
						nxt.fidx = pick[1:0]; // RULE15
					end else begin
						nxt.scr = rcc_pkg::SCR_STATUS; // RULE15
					end
				end
			end
			rcc_pkg::SCR_HIST: begin
				if (rise[rcc_pkg::BT_MENU]) begin
					nxt.scr = rcc_pkg::SCR_STATUS; // RULE15
				end else if (rise[rcc_pkg::BT_HIST]) begin
					if ({1'b0, st.hidx} + 4'h1 >= st.hcnt) begin
						nxt.hidx = 3'h0; // RULE16
					end else begin
						nxt.hidx = st.hidx + 3'h1; // RULE16
					end
				end
			end
			rcc_pkg::SCR_HOURS, rcc_pkg::SCR_CHECKS: begin
				if (rise[rcc_pkg::BT_MENU]) begin
					nxt.scr = rcc_pkg::SCR_STATUS;
				end
			end
			default: begin
				nxt.scr = rcc_pkg::SCR_STATUS;
			end
		endcase

		// ------------------------------------------------------------
		// APB slave
		// ------------------------------------------------------------
		case (i_paddr)
			rcc_pkg::A_CTRL: rd_mux = {31'h0, st.legacy};
			rcc_pkg::A_STATUS: rd_mux = {
				11'h0,
				st.scr,
				st.pin_s2,
				st.sen_s2,
				st.db,
				st.proc_rst,
				st.phase_lock,
				st.cold_on,
				st.comp_on
			};
			rcc_pkg::A_DISP: rd_mux = {
				20'h0,
				st.hcnt,
				st.hidx,
				hcode,
				1'b0,
				st.fidx
			};
			rcc_pkg::A_RUNTIME: rd_mux = st.run_sec;
			default: rd_mux = 32'h0;
		endcase
		if (i_psel && !st.latched) begin
			nxt.latched = 1'b1;
			nxt.prdata  = i_pwrite ? 32'h0 : rd_mux;
			nxt.slverr  = ~addr_ok(i_paddr);
		end else if (acc && st.latched) begin
			nxt.latched = 1'b0;
			if (i_pwrite && i_paddr == rcc_pkg::A_CTRL) begin
				nxt.legacy = i_pwdata[rcc_pkg::CTRL_LEGACY];
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= rcc_pkg::ST_RST;
		end else if (i_ce) begin
			st <= nxt;
		end
	end

endmodule

// ===== rcc_monitor.sv
/*
 Checker for the remote contact block, bound to its top-level ports.
 Assumes a bench that keeps i_ce high and pulls the status wires up.
*/
`timescale 1ns/1ps
module rcc_monitor #(
	parameter int unsigned RESET_HOLD_CYCLES = 40
) (
	// Clock, reset, enable
	input wire logic       i_clk,
	input wire logic       i_rst_n,
	input wire logic       i_ce,
	// APB
	input wire logic       i_psel,
	input wire logic       i_penable,
	input wire logic [7:0] i_paddr,
	input wire logic       o_pready,
	input wire logic       o_pslverr,
	// Contacts, buttons, sensors
	input wire logic [2:0] i_contact_n,
	input wire logic       i_btn_off,
	input wire logic       i_low_press,
	input wire logic       i_over_temp,
	input wire logic       i_phase_fault,
	// Status pins and drives
	input wire logic [3:0] o_stat_o,
	input wire logic [3:0] o_stat_oe,
	input wire logic       o_comp_on,
	input wire logic       o_cold_on,
	input wire logic       o_valve_on,
	input wire logic       o_proc_rst
);
	// ----------------------------------------------------------------
	// Helper state
	// ----------------------------------------------------------------
	logic [31:0] low_cnt;
	logic        phase_seen;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			low_cnt    <= '0;
			phase_seen <= 1'b0;
		end else begin
			low_cnt    <= i_contact_n[0] ? '0 : low_cnt + 32'h1;
			phase_seen <= phase_seen | o_stat_oe[1];
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	chk_drive_low: assert property (o_stat_o == 4'h0)
		else $error("status data not low");
	chk_run_pin: assert property (
		o_stat_oe[3] == (o_comp_on || o_cold_on))
		else $error("run pin wrong");
	chk_press_clear: assert property (
		(!i_low_press)[*6] |=> !o_stat_oe[0])
		else $error("pressure alarm stuck");
	chk_temp_set: assert property (
		i_over_temp[*6] |=> o_stat_oe[2] && !o_comp_on && !o_cold_on)
		else $error("over temperature not handled");
	chk_temp_clear: assert property (
		(!i_over_temp)[*6] |=> !o_stat_oe[2])
		else $error("temperature alarm stuck");
	chk_phase_set: assert property (
		i_phase_fault[*6] |=> o_stat_oe[1])
		else $error("phase pin missing");
	chk_phase_block: assert property (
		phase_seen && !o_comp_on |=> !o_comp_on)
		else $error("start after phase fault");
	chk_off_wins: assert property (
		i_btn_off[*8] |=> !o_comp_on && !o_cold_on && !o_valve_on)
		else $error("off button ignored");
	chk_rst_hold: assert property (
		$rose(o_proc_rst) |-> low_cnt >= RESET_HOLD_CYCLES)
		else $error("processor reset too early");
	chk_rst_release: assert property (
		i_contact_n[0][*8] |=> !o_proc_rst)
		else $error("processor reset stuck");
	chk_apb_ready: assert property (
		(i_psel && !i_penable && i_ce) ##1 (i_psel && i_penable)
		|-> o_pready)
		else $error("access phase not ready");
	chk_apb_err: assert property (
		o_pready && i_paddr > 8'h10 |-> o_pslverr)
		else $error("unmapped access without error");

	cover property ($rose(o_comp_on));
	cover property ($rose(o_proc_rst));
	cover property (o_pready && o_pslverr);
endmodule

bind remote_contact_control_status rcc_monitor #(
	.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)
) mon (
	.i_clk, .i_rst_n, .i_ce, .i_psel, .i_penable, .i_paddr, .o_pready,
	.o_pslverr, .i_contact_n, .i_btn_off, .i_low_press, .i_over_temp,
	.i_phase_fault, .o_stat_o, .o_stat_oe, .o_comp_on, .o_cold_on,
	.o_valve_on, .o_proc_rst
);

// ===== contact_panel.sv
/*
 Switch panel model: drives the three contacts, loads the status wires.
 Assumes the bench commands it through its tasks, at rising edges.
*/
`timescale 1ns/1ps
module contact_panel (
	// Clock and status pull-downs
	input  wire logic       i_clk,
	input  wire logic [3:0] i_oe,
	// Contacts and resolved wires
	output logic      [2:0] o_contact_n,
	output logic      [3:0] o_wire
);
	// ----------------------------------------------------------------
	// Wires and contacts
	// ----------------------------------------------------------------
	assign o_wire = ~i_oe;

	initial o_contact_n = 3'h7;

	// Shorts or opens contact k at the next rising edge, then waits n cycles
	task automatic set(input int k, input logic shorted, input int n);
		@(posedge i_clk);
		o_contact_n[k] <= !shorted;
		repeat (n) @(posedge i_clk);
	endtask

	// Reissue a command by flipping the contact away for n+1 cycles, then back for n cycles
	task automatic repeat_cmd(input int k, input logic on, input int n);
		set(k, !on, n);
		set(k, on, n);
	endtask
endmodule

// ===== remote_contact_control_status_test.sv
/*
 Self-checking bench for the remote contact block: APB access,
 contact commands, buttons, alarms, screens and legacy mode.
 Assumes the panel model and the bound checker.
*/
`timescale 1ns/1ps
module remote_contact_control_status_test;
	localparam int HOLD = 10;
	logic        i_clk, i_rst_n, i_psel, i_penable, i_pwrite;
	logic [7:0]  i_paddr;
	logic [31:0] i_pwdata, o_prdata, rd;
	logic        o_pready, o_pslverr, slv;
	logic [3:0]  btn, i_stat_pin, o_stat_o, o_stat_oe;
	logic [2:0]  sens, i_contact_n;
	logic        o_comp_on, o_cold_on, o_valve_on, o_proc_rst;
	logic [1:0]  hc [4];
	int          errors, checks, cyc;
	wire  [7:0]  outs = {o_stat_oe, o_comp_on, o_cold_on, o_valve_on,
		o_proc_rst};

	remote_contact_control_status #(
		.DEBOUNCE_CYCLES(4), .RESET_HOLD_CYCLES(40),
		.INIT_CYCLES(8), .SECOND_CYCLES(10)
	) uut (
		.i_clk, .i_rst_n, .i_ce(1'b1), .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
		.i_contact_n, .i_btn_off(btn[0]), .i_btn_on(btn[1]),
		.i_btn_menu(btn[2]), .i_btn_hist(btn[3]), .i_low_press(sens[0]),
		.i_over_temp(sens[1]), .i_phase_fault(sens[2]), .i_stat_pin,
		.o_stat_o, .o_stat_oe, .o_comp_on, .o_cold_on, .o_valve_on,
		.o_proc_rst
	);

	contact_panel panel (
		.i_clk, .i_oe(o_stat_oe), .o_contact_n(i_contact_n),
		.o_wire(i_stat_pin)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		i_psel   <= 1'b1;
		i_pwrite <= wr;
		i_paddr  <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		do @(negedge i_clk); while (o_pready !== 1'b1 && ++n < 50);
		@(posedge i_clk);
		rd  = o_prdata;
		slv = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
		if (n == 50) begin
			errors++;
			test_done();
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
			input logic ee);
		apb(1'b0, a, 32'h0);
		check(rd, e);
		check(slv, ee);
	endtask

	task automatic scr(input logic [2:0] e);
		apb(1'b0, 8'h04, 32'h0);
		check(rd[20:18], e);
	endtask

	task automatic press(input int k);
		@(posedge i_clk);
		btn[k] <= 1'b1;
		tick(HOLD);
		btn[k] <= 1'b0;
		tick(HOLD);
	endtask

	task automatic sense(input logic [2:0] v);
		@(posedge i_clk);
		sens <= v;
		tick(HOLD);
	endtask

	task automatic exp_o(input logic [7:0] e);
		@(negedge i_clk);
		check(outs, e);
	endtask

	task test_done;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, timeout, sequence
	// ----------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			test_done();
		end
	end

	initial begin
		{i_rst_n, i_psel, i_penable, i_pwrite, btn, sens} = '0;
		i_paddr  = '0;
		i_pwdata = '0;
		hc = '{2'h2, 2'h1, 2'h1, 2'h2};
		tick(2);
		i_rst_n <= 1'b1;
		tick(12);
		scr(3'h1);
		rd_chk(8'h00, 32'h0, 1'b0);
		apb(1'b1, 8'h00, 32'h1);
		rd_chk(8'h00, 32'h1, 1'b0);
		apb(1'b1, 8'h00, 32'h0);
		rd_chk(8'h20, 32'h0, 1'b1);
		panel.set(2, 1'b1, 2);
		panel.set(2, 1'b0, HOLD);
		exp_o(8'h00);
		panel.set(2, 1'b1, HOLD);
		exp_o(8'h8a);
		panel.set(1, 1'b1, HOLD);
		exp_o(8'h8e);
		apb(1'b1, 8'h10, 32'h3);
		exp_o(8'h00);
		panel.repeat_cmd(2, 1'b1, HOLD);
		exp_o(8'h8a);
		panel.set(2, 1'b0, HOLD);
		exp_o(8'h00);
		apb(1'b1, 8'h10, 32'h5);
		exp_o(8'h8a);
		panel.repeat_cmd(2, 1'b0, HOLD);
		exp_o(8'h00);
		press(1);
		exp_o(8'h8e);
		press(0);
		exp_o(8'h00);
		sense(3'h1);
		press(1);
		exp_o(8'h00);
		sense(3'h0);
		press(1);
		sense(3'h1);
		exp_o(8'h9e);
		sense(3'h2);
		exp_o(8'h40);
		sense(3'h0);
		exp_o(8'h00);
		press(2);
		scr(3'h2);
		press(2);
		scr(3'h1);
		foreach (hc[i]) begin
			press(3);
			apb(1'b0, 8'h08, 32'h0);
			check(rd[4:3], hc[i]);
		end
		press(2);
		scr(3'h1);
		panel.set(0, 1'b1, 20);
		exp_o(8'h00);
		panel.set(0, 1'b0, HOLD);
		panel.set(0, 1'b1, 60);
		exp_o(8'h01);
		panel.set(0, 1'b0, HOLD);
		exp_o(8'h00);
		sense(3'h4);
		exp_o(8'h20);
		sense(3'h0);
		press(1);
		@(negedge i_clk);
		check(outs[3:0], 4'h0);
		panel.set(2, 1'b1, HOLD);
		exp_o(8'h00);
		tick(1);
		i_rst_n <= 1'b0;
		tick(2);
		i_rst_n <= 1'b1;
		apb(1'b1, 8'h00, 32'h1);
		tick(HOLD);
		exp_o(8'h8e);
		apb(1'b0, 8'h04, 32'h0);
		check(rd[17:14], 4'h7);
		press(2);
		scr(3'h4);
		press(0);
		exp_o(8'h00);
		press(2);
		sense(3'h1);
		press(1);
		exp_o(8'h00);
		press(2);
		scr(3'h5);
		test_done();
	end
endmodule
